// File: pkg/ahbp_pkg.sv
// ahbp_pkg: constants and carriers for the async host bus port
// assumes one 10 MHz system clock; host pins already synchronous to it
package ahbp_pkg;
  localparam int unsigned ADDR_W      = 7;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned NUM_REGS    = 128;
  localparam logic [7:0]  REG_RST_VAL = 8'h00;
  localparam logic        SEL_PINS    = 1'b1;
  localparam logic        BUS_MOTO    = 1'b1;

  typedef enum logic [2:0] {
    AHBP_IDLE  = 3'b001,
    AHBP_ADDR  = 3'b010,
    AHBP_CYCLE = 3'b100
  } ahbp_state_t;

  // host pins as seen by the port
  typedef struct packed {
    logic              addr_latch_or_addr_strobe;
    logic              wr_rw;
    logic              read_strobe_or_data_strobe;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data_in;
  } ahbp_pins_t;

  // one access towards the register store
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ahbp_req_t;
endpackage

// File: verilog/ahbp_regmem.sv
// ahbp_regmem: small register store, registered read data
// assumes one access per cycle from the host port
`timescale 1ns/1ps
module ahbp_regmem
  import ahbp_pkg::*;
#(
  parameter int unsigned DEPTH = NUM_REGS
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_srst,
  input  wire logic              i_wr,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  output logic      [DATA_W-1:0] o_rdata
);
  logic [DATA_W-1:0] mem_r [DEPTH];
  logic [DATA_W-1:0] rdata_r;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      for (int i = 0; i < int'(DEPTH); i++) begin
        mem_r[i] <= REG_RST_VAL;
      end
      rdata_r <= REG_RST_VAL;
    end else begin
      if (i_wr) begin
        mem_r[i_addr] <= i_wdata;
      end
      rdata_r <= i_wr ? i_wdata : mem_r[i_addr];
    end
  end

  assign o_rdata = rdata_r;
endmodule // ahbp_regmem

// File: verilog/ahbp_port.sv
// ahbp_port: host/pins mode select, intel or motorola async cycle decode,
// hardware-mode send-all-ones commands
// assumes host pins are synchronous to i_clk_sys (edges seen as level changes)
`timescale 1ns/1ps

// Functional notes
// - select high means pin-programmed mode
// - select low means host mode
// - pin mode disables port; pins configure
// - intel write strobe low enables data input
// - intel write captures data on strobe rise
// - motorola read when flag high at strobe fall
// - motorola write when flag low at strobe fall
// - intel read strobe low drives register data
// - intel read strobe high releases data bus
// - pin mode: strobes become ch0/ch1 all-ones
// - intel address latched on latch-enable fall
module ahbp_port
  import ahbp_pkg::*;
(
  input  wire logic              i_clk_sys,
  input  wire logic              i_srst,
  input  wire logic              i_host_or_pins_select,
  input  wire logic              i_bus_style_moto,
  input  wire logic              i_addr_latch_or_addr_strobe,
  input  wire logic              i_write_or_rw_flag,
  input  wire logic              i_read_strobe_or_data_strobe,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_data_in,
  output logic      [DATA_W-1:0] o_data_out,
  output logic      [DATA_W-1:0] o_data_oe,
  output logic                   o_data_in_en,
  output logic                   o_host_mode,
  output logic                   o_send_all_ones_ch0,
  output logic                   o_send_all_ones_ch1
);
  ahbp_pins_t        pins;
  ahbp_pins_t        prev_r;
  ahbp_pins_t        prev_nxt;
  ahbp_state_t       state_r;
  ahbp_state_t       state_nxt;
  ahbp_req_t         req;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] dout_r;
  logic [DATA_W-1:0] dout_nxt;
  logic              oe_r;
  logic              oe_nxt;
  logic              in_en_r;
  logic              in_en_nxt;
  logic              host_r;
  logic              host_nxt;
  logic              taos0_r;
  logic              taos0_nxt;
  logic              taos1_r;
  logic              taos1_nxt;
  logic              moto_rd_r;
  logic              moto_rd_nxt;
  logic              arm_r;
  logic              arm_nxt;
  logic              ale_fell;
  logic              wr_rose;
  logic              ds_fell;
  logic              rd_rose;

  function automatic logic fell(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction

  function automatic logic rose(input logic prev, input logic cur);
    return ~prev & cur;
  endfunction

  assign pins = '{addr_latch_or_addr_strobe:  i_addr_latch_or_addr_strobe,
                  wr_rw:   i_write_or_rw_flag,
                  read_strobe_or_data_strobe:   i_read_strobe_or_data_strobe,
                  addr:    i_addr,
                  data_in: i_data_in};

  // a mode change can fake an edge; count edges only on host history
  assign ale_fell = arm_r & fell(prev_r.addr_latch_or_addr_strobe, pins.addr_latch_or_addr_strobe);
  assign wr_rose  = arm_r & rose(prev_r.wr_rw, pins.wr_rw);
  assign ds_fell  = arm_r & fell(prev_r.read_strobe_or_data_strobe, pins.read_strobe_or_data_strobe);
  assign rd_rose  = arm_r & rose(prev_r.read_strobe_or_data_strobe, pins.read_strobe_or_data_strobe);

  // store reads the latched address every cycle
  ahbp_regmem #(
    .DEPTH (NUM_REGS)
  ) ahbp_regmem_i (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_wr      (req.wr),
    .i_addr    (req.addr),
    .i_wdata   (req.wdata),
    .o_rdata   (rdata)
  );

  always_comb begin
    host_nxt    = (i_host_or_pins_select != SEL_PINS);
    prev_nxt    = pins;
    state_nxt   = state_r;
    addr_nxt    = addr_r;
    dout_nxt    = dout_r;
    oe_nxt      = 1'b0;
    in_en_nxt   = 1'b0;
    moto_rd_nxt = moto_rd_r;
    arm_nxt     = host_r;
    req         = '{wr: 1'b0, rd: 1'b0, addr: addr_r, wdata: pins.data_in};
    if (!host_r) begin
      // port dead; strobe pins feed the command group below
      state_nxt   = AHBP_IDLE;
      moto_rd_nxt = 1'b0;
    end else if (i_bus_style_moto != BUS_MOTO) begin
      // latch enable high lets the address through; its fall freezes it
      if (pins.addr_latch_or_addr_strobe) begin
        addr_nxt = pins.addr;
      end
      if (ale_fell) begin
        addr_nxt  = prev_r.addr;
        req.addr  = prev_r.addr;
        state_nxt = AHBP_CYCLE;
      end
      in_en_nxt = ~pins.wr_rw;
      // data is the last sample taken with the strobe still low
      if (wr_rose) begin
        req.wr    = 1'b1;
        req.wdata = prev_r.data_in;
        state_nxt = AHBP_IDLE;
      end
      if (!pins.read_strobe_or_data_strobe) begin
        oe_nxt   = 1'b1;
        dout_nxt = rdata;
      end else if (rd_rose) begin
        state_nxt = AHBP_IDLE;
      end
    end else begin
      // address strobe low holds the address for the whole cycle
      if (!pins.addr_latch_or_addr_strobe) begin
        if (state_r == AHBP_IDLE) begin
          addr_nxt  = pins.addr;
          req.addr  = pins.addr;
          state_nxt = AHBP_ADDR;
        end
      end else begin
        state_nxt   = AHBP_IDLE;
        moto_rd_nxt = 1'b0;
      end
      // the flag level at the data-strobe fall picks read or write
      if (ds_fell) begin
        if (pins.wr_rw) begin
          moto_rd_nxt = 1'b1;
        end else begin
          req.wr    = 1'b1;
          req.wdata = pins.data_in;
        end
        state_nxt = AHBP_CYCLE;
      end
      if (pins.read_strobe_or_data_strobe) begin
        moto_rd_nxt = 1'b0;
      end
      in_en_nxt = ~pins.wr_rw & ~pins.read_strobe_or_data_strobe;
      if (moto_rd_r && !pins.read_strobe_or_data_strobe) begin
        oe_nxt   = 1'b1;
        dout_nxt = rdata;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      prev_r    <= '{addr_latch_or_addr_strobe: 1'b0, wr_rw: 1'b1, read_strobe_or_data_strobe: 1'b1,
                     addr: '0, data_in: '0};
      state_r   <= AHBP_IDLE;
      addr_r    <= '0;
      dout_r    <= REG_RST_VAL;
      oe_r      <= 1'b0;
      in_en_r   <= 1'b0;
      host_r    <= 1'b0;
      arm_r     <= 1'b0;
      moto_rd_r <= 1'b0;
    end else begin
      prev_r    <= prev_nxt;
      state_r   <= state_nxt;
      addr_r    <= addr_nxt;
      dout_r    <= dout_nxt;
      oe_r      <= oe_nxt;
      in_en_r   <= in_en_nxt;
      host_r    <= host_nxt;
      arm_r     <= arm_nxt;
      moto_rd_r <= moto_rd_nxt;
    end
  end

  // pin-mode commands: strobe pins become per-channel levels
  always_comb begin
    taos0_nxt = 1'b0;
    taos1_nxt = 1'b0;
    if (!host_r) begin
      taos0_nxt = pins.wr_rw;
      taos1_nxt = pins.read_strobe_or_data_strobe;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      taos0_r <= 1'b0;
      taos1_r <= 1'b0;
    end else begin
      taos0_r <= taos0_nxt;
      taos1_r <= taos1_nxt;
    end
  end

  assign o_data_out          = dout_r;
  assign o_data_oe           = {DATA_W{oe_r}};
  assign o_data_in_en        = in_en_r;
  assign o_host_mode         = host_r;
  assign o_send_all_ones_ch0 = taos0_r;
  assign o_send_all_ones_ch1 = taos1_r;
endmodule // ahbp_port

// File: bench/ahbp_port_properties.sv
// ahbp_port_chk: pin timing checks on ahbp_port
// assumes select is held high through reset
`timescale 1ns/1ps
module ahbp_port_chk
  import ahbp_pkg::*;
(
  input wire logic              i_clk_sys,
  input wire logic              i_srst,
  input wire logic              i_host_or_pins_select,
  input wire logic              i_bus_style_moto,
  input wire logic              i_write_or_rw_flag,
  input wire logic              i_read_strobe_or_data_strobe,
  input wire logic [DATA_W-1:0] o_data_oe,
  input wire logic              o_data_in_en,
  input wire logic              o_host_mode,
  input wire logic              o_send_all_ones_ch0,
  input wire logic              o_send_all_ones_ch1
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  logic s, w, r, it, mt;
  assign {s, w, r} = {i_host_or_pins_select, i_write_or_rw_flag, i_read_strobe_or_data_strobe};
  assign it = o_host_mode && !i_bus_style_moto;
  assign mt = o_host_mode && i_bus_style_moto;
  chk_host_sel: assert property (!$past(i_srst) |-> o_host_mode == !$past(s))
    else $error("host mode wrong");
  chk_pin_cmds: assert property (!$past(i_srst) && $past(s, 2)
    |-> {o_send_all_ones_ch0, o_send_all_ones_ch1} == $past({w, r})) else $error("pin cmd");
  chk_pin_off: assert property ($past(s, 2) |-> o_data_oe == 8'h00 && !o_data_in_en)
    else $error("bus on in pin mode");
  chk_wr_buffer: assert property (it && !w |=> o_data_in_en) else $error("no input enable");
  chk_rd_drive: assert property (it && $fell(r) |=> o_data_oe == 8'hff)
    else $error("no drive");
  chk_rd_free: assert property (it && $rose(r) |=> o_data_oe == 8'h00)
    else $error("no release");
  chk_moto_rd: assert property (mt && $past(o_host_mode) && $fell(r) && w
    |-> ##2 o_data_oe == 8'hff) else $error("moto read");
  chk_moto_wr: assert property (mt && $past(o_host_mode) && $fell(r) && !w
    |-> ##2 o_data_oe == 8'h00) else $error("moto write");
endmodule // ahbp_port_chk
bind ahbp_port ahbp_port_chk ahbp_port_chk_i (.*);

// File: bench/ahbp_cpu_model.sv
// ahbp_cpu_model: host processor on the port pins
// assumes i_moto changes only between accesses
`timescale 1ns/1ps
module ahbp_cpu_model
  import ahbp_pkg::*;
(
  input  wire logic              i_clk_sys,
  input  wire logic              i_moto,
  input  wire logic [DATA_W-1:0] i_data_out,
  input  wire logic [DATA_W-1:0] i_data_oe,
  output ahbp_pins_t             o_pins
);
  logic              ale = 1'b0, wr = 1'b1, rd = 1'b1, own = 1'b0;
  logic [ADDR_W-1:0] addr = 7'h00;
  logic [DATA_W-1:0] drv = 8'h00;
  // released bus shows the inverse of the last byte
  assign o_pins = {ale, wr, rd, addr, |i_data_oe ? i_data_out : own ? drv : ~drv};
  task automatic step(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic hold(input logic w, input logic r);
    {ale, wr, rd} = {i_moto, w, r};
    step(2);
  endtask
  task automatic access(input logic op, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
    {addr, ale, drv, own} = {a, !i_moto, d, !op};
    step(2);
    {ale, wr} = {1'b0, !i_moto | op};
    step(2);
    if (i_moto || op) rd = 1'b0;
    else wr = 1'b0;
    step(5);
    q = o_pins.data_in;
    {wr, rd} = 2'h3;
    step(2);
    {ale, own} = {i_moto, 1'b0};
    step(1);
  endtask
endmodule // ahbp_cpu_model

// File: bench/async_host_bus_port_tb.sv
// async_host_bus_port_tb: pin, intel and motorola runs
// assumes the cpu model paces every access
`timescale 1ns/1ps
module async_host_bus_port_tb;
  import ahbp_pkg::*;
  logic              clk = 1'b0, srst = 1'b1, sel = 1'b1, moto = 1'b0, ho, c0, c1, ien;
  logic [DATA_W-1:0] dout, oe, q;
  wire  [7:0]        fl = {4'h0, ho, c0, c1, ien};
  ahbp_pins_t        p;
  int                n_errors = 0, checks_done = 0;
  ahbp_port ahbp_port_i (.i_clk_sys(clk), .i_srst(srst), .i_host_or_pins_select(sel),
    .i_bus_style_moto(moto), .i_addr_latch_or_addr_strobe(p.addr_latch_or_addr_strobe), .i_addr(p.addr),
    .i_write_or_rw_flag(p.wr_rw), .i_read_strobe_or_data_strobe(p.read_strobe_or_data_strobe),
    .i_data_in(p.data_in), .o_data_out(dout), .o_data_oe(oe), .o_data_in_en(ien),
    .o_host_mode(ho), .o_send_all_ones_ch0(c0), .o_send_all_ones_ch1(c1));
  ahbp_cpu_model ahbp_cpu_model_i (.i_clk_sys(clk), .i_moto(moto), .i_data_out(dout),
    .i_data_oe(oe), .o_pins(p));
  initial forever #50 clk = ~clk;
  task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic close_out;
    if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic t_pins;
    ahbp_cpu_model_i.hold(1'b1, 1'b0);
    check("ch0", fl, 8'h04);
    ahbp_cpu_model_i.hold(1'b0, 1'b1);
    check("ch1", fl, 8'h02);
    ahbp_cpu_model_i.hold(1'b1, 1'b1);
  endtask
  task automatic t_intel;
    sel = 1'b0;
    ahbp_cpu_model_i.hold(1'b1, 1'b1);
    check("host", fl, 8'h08);
    ahbp_cpu_model_i.hold(1'b0, 1'b1);
    check("in en", fl, 8'h09);
    ahbp_cpu_model_i.hold(1'b1, 1'b1);
    ahbp_cpu_model_i.access(1'b0, 7'h7f, 8'h5a, q);
    ahbp_cpu_model_i.access(1'b0, 7'h00, 8'ha5, q);
    ahbp_cpu_model_i.access(1'b1, 7'h7f, 8'h00, q);
    check("rd 7f", q, 8'h5a);
    ahbp_cpu_model_i.access(1'b1, 7'h00, 8'h00, q);
    check("rd 00", q, 8'ha5);
    check("oe", oe, 8'h00);
  endtask
  task automatic t_moto;
    moto = 1'b1;
    ahbp_cpu_model_i.step(1);
    ahbp_cpu_model_i.hold(1'b1, 1'b1);
    ahbp_cpu_model_i.access(1'b0, 7'h12, 8'h3c, q);
    ahbp_cpu_model_i.access(1'b1, 7'h12, 8'h00, q);
    check("m rd 12", q, 8'h3c);
    ahbp_cpu_model_i.access(1'b1, 7'h7f, 8'h00, q);
    check("m rd 7f", q, 8'h5a);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #1;
    srst = 1'b0;
    ahbp_cpu_model_i.step(2);
    t_pins;
    t_intel;
    t_moto;
    close_out;
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    close_out;
  end
endmodule // async_host_bus_port_tb
